// >>> common/bfpf_defines.svh
// Constants for the bidirectional two-queue buffer with partial flags.
// Included by the package and by the checker; definitions only.
`ifndef BFPF_DEFINES_SVH
`define BFPF_DEFINES_SVH

// ----------------------------------------------------------------
// Widths and depths
// ----------------------------------------------------------------
`define BFPF_DW 36
`define BFPF_DEPTH 16
`define BFPF_CNT_W 5
`define BFPF_THR_W 7
`define BFPF_NTHR 4
`define BFPF_SER_BITS 28
`define BFPF_SER_CNT_W 5

// ----------------------------------------------------------------
// Threshold slots and defaults
// ----------------------------------------------------------------
`define BFPF_T_A_EMPTY 2'h0
`define BFPF_T_A_FULL 2'h1
`define BFPF_T_B_EMPTY 2'h2
`define BFPF_T_B_FULL 2'h3
`define BFPF_OFS_8 7'h08
`define BFPF_OFS_16 7'h10
`define BFPF_OFS_64 7'h40
`define BFPF_SEL_8 2'h0
`define BFPF_SEL_16 2'h1
`define BFPF_SEL_64 2'h2
// Straps need three sampler stages plus one filter stall to settle
`define BFPF_STRAP_WAIT 3'h6
// Reset flag state: near-empty low, near-full high, both sides
`define BFPF_FLAG_RST 4'b1010

// ----------------------------------------------------------------
// Register map (word indices, matched against adr[4:2] of the byte address)
// ----------------------------------------------------------------
`define BFPF_REG_A_EMPTY 3'h0
`define BFPF_REG_A_FULL 3'h1
`define BFPF_REG_B_EMPTY 3'h2
`define BFPF_REG_B_FULL 3'h3
`define BFPF_REG_STATUS 3'h4
`define BFPF_ST_FCNT_LSB 0
`define BFPF_ST_RCNT_LSB 8
`define BFPF_ST_FLAG_LSB 16

`endif

// >>> common/bfpf_pkg.sv
// Types shared by the buffer design.
// Assumes bfpf_defines.svh is on the include path.
`include "bfpf_defines.svh"

package bfpf_pkg;
  // One side's pin group, carried through the synchroniser together
  typedef struct packed {
    logic clk;
    logic wr;
    logic rd;
    logic ld;
    logic sd;
    logic serial_program_select;
    logic fs0;
    logic fs1;
    logic [`BFPF_DW-1:0] data;
  } bfpf_pins_s;

  typedef logic [`BFPF_THR_W-1:0] bfpf_thr_t;
endpackage

// >>> design/bfpf_top.sv
// Bidirectional two-queue buffer with programmable partial flags.
// Assumes one 10 MHz clk_i; side clocks and pins arrive asynchronously
// and are sampled; software reaches thresholds over classic Wishbone.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// FIFO with valid/ready on both sides
// ----------------------------------------------------------------
module bfpf_fifo #(
  parameter int W = 36,
  parameter int D = 16,
  parameter int CW = 5
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  // Fill level
  output logic [CW-1:0] count_o
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready_o = (cnt_q != CW'(D));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rp_q];
  assign count_o = cnt_q;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Pointer and level update; wrap relies on D being a power of two
  always_comb begin
    wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
    rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
    cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage holds no reset; only valid words are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------------------------------
// Three-flop pin sampler with agreement filter and clock-edge detect
// ----------------------------------------------------------------
module bfpf_pin_sync
  import bfpf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pins and filtered result
  input wire bfpf_pins_s pins_i,
  output bfpf_pins_s pins_o,
  output logic edge_o
);
  bfpf_pins_s s1_q, s2_q, s3_q, st_q, st_d;
  logic prev_q, prev_d;

  // A change is taken only once stages two and three agree
  always_comb begin
    st_d = st_q;
    if (s2_q == s3_q) begin
      st_d = s3_q;
    end
    prev_d = st_q.clk;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
      prev_q <= 1'b0;
    end else begin
      s1_q <= pins_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
      prev_q <= prev_d;
    end
  end

  assign pins_o = st_q;
  assign edge_o = st_q.clk & ~prev_q;
endmodule

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module bfpf_top
  import bfpf_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Side A pins
  input wire logic side_a_clock_i,
  input wire logic side_a_wr_i,
  input wire logic side_a_rd_i,
  input wire logic side_a_load_i,
  input wire logic [`BFPF_DW-1:0] side_a_data_bus_i,
  output logic [`BFPF_DW-1:0] side_a_data_bus_o,
  output logic side_a_data_bus_oe_o,
  output logic side_a_ready_o,
  output logic side_a_near_empty_flag_o,
  output logic side_a_near_full_flag_o,
  // Configuration pins
  input wire logic serial_offset_input_i,
  input wire logic serial_program_select_i,
  input wire logic default_offset_select_low_i,
  input wire logic default_offset_select_high_i,
  // Side B pins
  input wire logic side_b_clock_i,
  input wire logic side_b_wr_i,
  input wire logic side_b_rd_i,
  input wire logic [`BFPF_DW-1:0] side_b_data_bus_i,
  output logic [`BFPF_DW-1:0] side_b_data_bus_o,
  output logic side_b_data_bus_oe_o,
  output logic side_b_ready_o,
  output logic side_b_near_empty_flag_o,
  output logic side_b_near_full_flag_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  bfpf_pins_s a_raw, b_raw, a_p, b_p;
  logic a_edge, b_edge;
  logic f_in_rdy, f_out_vld, r_in_rdy, r_out_vld;
  logic [`BFPF_DW-1:0] f_head, r_head;
  logic [`BFPF_CNT_W-1:0] f_cnt, r_cnt;
  logic f_push, f_pop, r_push, r_pop;

  // Pin groups sampled as one struct per side
  assign a_raw = '{clk: side_a_clock_i, wr: side_a_wr_i, rd: side_a_rd_i,
                   ld: side_a_load_i, sd: serial_offset_input_i,
                   serial_program_select: serial_program_select_i,
                   fs0: default_offset_select_low_i,
                   fs1: default_offset_select_high_i, data: side_a_data_bus_i};
  assign b_raw = '{clk: side_b_clock_i, wr: side_b_wr_i, rd: side_b_rd_i,
                   ld: 1'b0, sd: 1'b0, serial_program_select: 1'b0, fs0: 1'b0, fs1: 1'b0,
                   data: side_b_data_bus_i};

  bfpf_pin_sync u_sync_a (
    .clk_i(clk_i), .rst_i(rst_i), .pins_i(a_raw), .pins_o(a_p), .edge_o(a_edge)
  );
  bfpf_pin_sync u_sync_b (
    .clk_i(clk_i), .rst_i(rst_i), .pins_i(b_raw), .pins_o(b_p), .edge_o(b_edge)
  );

  // ----------------------------------------------------------------
  // Queues: forward A->B, return B->A
  // ----------------------------------------------------------------
  // A load cycle on side A is not a data write
  assign f_push = a_edge & a_p.wr & ~a_p.ld;
  assign f_pop = b_edge & b_p.rd & f_out_vld;
  assign r_push = b_edge & b_p.wr;
  assign r_pop = a_edge & a_p.rd & r_out_vld;

  bfpf_fifo #(.W(`BFPF_DW), .D(`BFPF_DEPTH), .CW(`BFPF_CNT_W)) u_fwd (
    .clk_i(clk_i), .rst_i(rst_i),
    .in_valid_i(f_push), .in_ready_o(f_in_rdy), .in_data_i(a_p.data),
    .out_valid_o(f_out_vld), .out_ready_i(f_pop), .out_data_o(f_head),
    .count_o(f_cnt)
  );
  bfpf_fifo #(.W(`BFPF_DW), .D(`BFPF_DEPTH), .CW(`BFPF_CNT_W)) u_ret (
    .clk_i(clk_i), .rst_i(rst_i),
    .in_valid_i(r_push), .in_ready_o(r_in_rdy), .in_data_i(b_p.data),
    .out_valid_o(r_out_vld), .out_ready_i(r_pop), .out_data_o(r_head),
    .count_o(r_cnt)
  );

  // ----------------------------------------------------------------
  // Data ports: read word held until the next read
  // ----------------------------------------------------------------
  logic [`BFPF_DW-1:0] a_do_q, a_do_d, b_do_q, b_do_d;
  logic a_oe_q, a_oe_d, b_oe_q, b_oe_d, a_rdy_q, a_rdy_d, b_rdy_q, b_rdy_d;

  always_comb begin
    a_do_d = r_pop ? r_head : a_do_q;
    b_do_d = f_pop ? f_head : b_do_q;
    a_oe_d = a_p.rd;
    b_oe_d = b_p.rd;
    a_rdy_d = f_in_rdy;
    b_rdy_d = r_in_rdy;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_do_q <= '0;
      b_do_q <= '0;
      a_oe_q <= 1'b0;
      b_oe_q <= 1'b0;
      a_rdy_q <= 1'b0;
      b_rdy_q <= 1'b0;
    end else begin
      a_do_q <= a_do_d;
      b_do_q <= b_do_d;
      a_oe_q <= a_oe_d;
      b_oe_q <= b_oe_d;
      a_rdy_q <= a_rdy_d;
      b_rdy_q <= b_rdy_d;
    end
  end

  // ----------------------------------------------------------------
  // Threshold registers: defaults, side A loading, Wishbone writes
  // ----------------------------------------------------------------
  bfpf_thr_t thr_q [`BFPF_NTHR];
  bfpf_thr_t thr_d [`BFPF_NTHR];
  logic pend_q, pend_d;
  logic [2:0] wait_q, wait_d;
  logic [1:0] pidx_q, pidx_d;
  logic [`BFPF_SER_BITS-1:0] sh_q, sh_d;
  logic [`BFPF_SER_CNT_W-1:0] scnt_q, scnt_d;
  bfpf_thr_t dflt;
  logic wb_hit, wb_wr;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Write lands at the acknowledged edge, while the request still stands
  assign wb_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  always_comb begin
    unique case ({a_p.fs1, a_p.fs0})
      `BFPF_SEL_8: dflt = `BFPF_OFS_8;
      `BFPF_SEL_16: dflt = `BFPF_OFS_16;
      `BFPF_SEL_64: dflt = `BFPF_OFS_64;
      default: dflt = `BFPF_OFS_8;
    endcase
  end

  // Straps are read only after the sampler has settled past reset
  always_comb begin
    thr_d = thr_q;
    pend_d = pend_q;
    wait_d = wait_q;
    pidx_d = pidx_q;
    sh_d = sh_q;
    scnt_d = scnt_q;
    if (pend_q) begin
      if (wait_q == `BFPF_STRAP_WAIT) begin
        for (int i = 0; i < `BFPF_NTHR; i++) begin
          thr_d[i] = dflt;
        end
        pend_d = 1'b0;
      end else begin
        wait_d = 3'(wait_q + 1'b1);
      end
    end else if (a_edge & a_p.ld) begin
      if (a_p.serial_program_select) begin
        // Serial: MSB first, A empty slot arrives first
        sh_d = {sh_q[`BFPF_SER_BITS-2:0], a_p.sd};
        if (scnt_q == `BFPF_SER_CNT_W'(`BFPF_SER_BITS - 1)) begin
          for (int i = 0; i < `BFPF_NTHR; i++) begin
            thr_d[i] = sh_d[`BFPF_THR_W*(`BFPF_NTHR-1-i) +: `BFPF_THR_W];
          end
          scnt_d = '0;
        end else begin
          scnt_d = `BFPF_SER_CNT_W'(scnt_q + 1'b1);
        end
      end else begin
        thr_d[pidx_q] = a_p.data[`BFPF_THR_W-1:0];
        pidx_d = 2'(pidx_q + 1'b1);
      end
    end
    // Software write wins over a pin load in the same cycle
    if (!pend_q && wb_wr && !wb_adr_i[4]) begin
      thr_d[wb_adr_i[3:2]] = wb_dat_i[`BFPF_THR_W-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < `BFPF_NTHR; i++) begin
        thr_q[i] <= `BFPF_OFS_8;
      end
      pend_q <= 1'b1;
      wait_q <= '0;
      pidx_q <= '0;
      sh_q <= '0;
      scnt_q <= '0;
    end else begin
      thr_q <= thr_d;
      pend_q <= pend_d;
      wait_q <= wait_d;
      pidx_q <= pidx_d;
      sh_q <= sh_d;
      scnt_q <= scnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Partial flags: compare every cycle, two stages on the side's edge
  // ----------------------------------------------------------------
  bfpf_thr_t f_lvl, r_lvl, f_free, r_free;
  logic [3:0] raw; // a_ne, a_nf, b_ne, b_nf; high means not near
  logic [3:0] st1_q, st1_d, st2_q, st2_d;

  always_comb begin
    f_lvl = `BFPF_THR_W'(f_cnt);
    r_lvl = `BFPF_THR_W'(r_cnt);
    f_free = `BFPF_THR_W'(`BFPF_DEPTH - f_cnt);
    r_free = `BFPF_THR_W'(`BFPF_DEPTH - r_cnt);
    raw[0] = r_lvl > thr_q[`BFPF_T_A_EMPTY];
    raw[1] = f_free > thr_q[`BFPF_T_A_FULL];
    raw[2] = f_lvl > thr_q[`BFPF_T_B_EMPTY];
    raw[3] = r_free > thr_q[`BFPF_T_B_FULL];
  end

  // A flags follow side A edges, B flags follow side B edges
  always_comb begin
    st1_d = st1_q;
    st2_d = st2_q;
    if (a_edge) begin
      st1_d[1:0] = raw[1:0];
      st2_d[1:0] = st1_q[1:0];
    end
    if (b_edge) begin
      st1_d[3:2] = raw[3:2];
      st2_d[3:2] = st1_q[3:2];
    end
  end

  // Reset state: queues empty, so near-empty low and near-full high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st1_q <= `BFPF_FLAG_RST;
      st2_q <= `BFPF_FLAG_RST;
    end else begin
      st1_q <= st1_d;
      st2_q <= st2_d;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone answer: ack one cycle after the strobe, zero if unmapped
  // ----------------------------------------------------------------
  logic [31:0] rd_d, rd_q;
  logic ack_d, ack_q;

  // Read word captured on the accepted request and held until the next one
  always_comb begin
    rd_d = rd_q;
    ack_d = wb_hit;
    if (wb_hit) begin
      rd_d = '0;
      if (!wb_adr_i[4]) begin
        rd_d[`BFPF_THR_W-1:0] = thr_q[wb_adr_i[3:2]];
      end else if (wb_adr_i[4:2] == `BFPF_REG_STATUS) begin
        rd_d[`BFPF_ST_FCNT_LSB +: `BFPF_CNT_W] = f_cnt;
        rd_d[`BFPF_ST_RCNT_LSB +: `BFPF_CNT_W] = r_cnt;
        rd_d[`BFPF_ST_FLAG_LSB +: 4] = st2_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rd_q <= '0;
      ack_q <= 1'b0;
    end else begin
      rd_q <= rd_d;
      ack_q <= ack_d;
    end
  end

  // Outputs, each from a flip-flop
  assign side_a_data_bus_o = a_do_q;
  assign side_a_data_bus_oe_o = a_oe_q;
  assign side_b_data_bus_o = b_do_q;
  assign side_b_data_bus_oe_o = b_oe_q;
  assign side_a_ready_o = a_rdy_q;
  assign side_b_ready_o = b_rdy_q;
  assign side_a_near_empty_flag_o = st2_q[0];
  assign side_a_near_full_flag_o = st2_q[1];
  assign side_b_near_empty_flag_o = st2_q[2];
  assign side_b_near_full_flag_o = st2_q[3];
  assign wb_dat_o = rd_q;
  assign wb_ack_o = ack_q;
endmodule

// >>> testbench/bfpf_top_props.sv
// Checker for the partial-flag buffer top level, bound in at the foot.
// Sees only the top ports; assumes the 10 MHz clk_i and its sync reset.
`timescale 1ns/1ns
`include "bfpf_defines.svh"
module bfpf_top_props (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Side pins
  input wire logic side_a_clock_i,
  input wire logic side_a_rd_i,
  input wire logic [`BFPF_DW-1:0] side_a_data_bus_o,
  input wire logic side_a_near_empty_flag_o,
  input wire logic side_a_near_full_flag_o,
  input wire logic side_b_clock_i,
  input wire logic side_b_rd_i,
  input wire logic [`BFPF_DW-1:0] side_b_data_bus_o,
  input wire logic side_b_near_empty_flag_o,
  input wire logic side_b_near_full_flag_o,
  // Wishbone
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus answer comes exactly one edge after the request, for one cycle
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  // Read words only move after a sampled read strobe, sampler latency included
  chk_a_rd_data: assert property (
    $changed(side_a_data_bus_o) |-> $past(side_a_rd_i, 5) || $past(side_a_rd_i, 6))
    else $error("side a data moved without read");
  chk_b_rd_data: assert property (
    $changed(side_b_data_bus_o) |-> $past(side_b_rd_i, 5) || $past(side_b_rd_i, 6))
    else $error("side b data moved without read");
  // Side A near-empty and side B near-full move only on their own side clock, never between edges
  chk_a_ne_edge: assert property (
    $changed(side_a_near_empty_flag_o) |-> $past(side_a_clock_i, 4))
    else $error("side a near-empty moved off its clock");
  chk_b_nf_edge: assert property (
    $changed(side_b_near_full_flag_o) |-> $past(side_b_clock_i, 4))
    else $error("side b near-full moved off its clock");
  // Status word mirrors the four flag pins
  chk_stat_flags: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[4:2] == 3'h4 |-> wb_dat_o[19:16] ==
    $past({side_b_near_full_flag_o, side_b_near_empty_flag_o,
    side_a_near_full_flag_o, side_a_near_empty_flag_o}))
    else $error("status flags differ from pins");
endmodule

bind bfpf_top bfpf_top_props u_props (
  .clk_i(clk_i), .rst_i(rst_i),
  .side_a_clock_i(side_a_clock_i), .side_a_rd_i(side_a_rd_i),
  .side_a_data_bus_o(side_a_data_bus_o),
  .side_a_near_empty_flag_o(side_a_near_empty_flag_o),
  .side_a_near_full_flag_o(side_a_near_full_flag_o),
  .side_b_clock_i(side_b_clock_i), .side_b_rd_i(side_b_rd_i),
  .side_b_data_bus_o(side_b_data_bus_o),
  .side_b_near_empty_flag_o(side_b_near_empty_flag_o),
  .side_b_near_full_flag_o(side_b_near_full_flag_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o)
);

// >>> testbench/bfpf_side_model.sv
// Host logic on one side port: free-running side clock, one transfer a call.
// Assumes the system clock; the side clock period is P system cycles.
`timescale 1ns/1ns
module bfpf_side_model #(
  parameter int P = 16
) (
  // System clock
  input wire logic clk_i,
  // Side pins
  output logic side_clk_o,
  output logic wr_o,
  output logic rd_o,
  output logic ld_o,
  output logic [35:0] data_o
);
  int cnt = 0;
  logic go = 1'b0;
  logic pw, pr, pl;
  logic [35:0] pd;
  initial begin
    {side_clk_o, wr_o, rd_o, ld_o} = 4'h0;
    data_o = 36'h0;
  end
  // Controls change on the falling side edge, half a period clear of each rise
  always @(posedge clk_i) begin
    cnt <= (cnt + 1) % P;
    side_clk_o <= (cnt + 1) % P < P / 2;
    if (cnt == P / 2 - 1) begin
      wr_o <= go & pw;
      rd_o <= go & pr;
      ld_o <= go & pl;
      if (go && (pw || pl)) data_o <= pd;
      else if (wr_o || ld_o) data_o <= ~data_o; // Released bus shows the inverse
      go = 1'b0;
    end
  end
  // One transfer; returns once the sampler has seen the next side rise
  task automatic ev(input logic w, input logic r, input logic l, input logic [35:0] d);
    {pw, pr, pl, pd} = {w, r, l, d};
    go = 1'b1;
    do @(posedge clk_i); while (go);
    repeat (P / 2 + 6) @(posedge clk_i);
  endtask
endmodule

// >>> testbench/bfpf_top_test.sv
// Self-checking bench for the partial-flag buffer top level.
// Assumes package, design, checker and side model are compiled first.
`timescale 1ns/1ns
module bfpf_top_test;
  import bfpf_pkg::*;
  logic clk_i, rst_i, sd, serial_program_select, fs0, fs1, cyc, stb, we;
  logic [4:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, q, rdat;
  logic [35:0] ma_d, mb_d, a_o, b_o;
  logic a_clk, a_wr, a_rd, a_ld, b_clk, b_wr, b_rd, a_oe, b_oe;
  logic a_rdy, b_rdy, a_ne, a_nf, b_ne, b_nf, ack;
  logic [27:0] ser = {7'h11, 7'h22, 7'h33, 7'h44};
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;
  int ofs [3] = '{8, 16, 64};
  // Device under test; each data pin sees whoever drives it
  bfpf_top u_dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .side_a_clock_i(a_clk), .side_a_wr_i(a_wr), .side_a_rd_i(a_rd), .side_a_load_i(a_ld),
    .side_a_data_bus_i(a_oe ? a_o : ma_d), .side_a_data_bus_o(a_o),
    .side_a_data_bus_oe_o(a_oe), .side_a_ready_o(a_rdy),
    .side_a_near_empty_flag_o(a_ne), .side_a_near_full_flag_o(a_nf),
    .serial_offset_input_i(sd), .serial_program_select_i(serial_program_select),
    .default_offset_select_low_i(fs0), .default_offset_select_high_i(fs1),
    .side_b_clock_i(b_clk), .side_b_wr_i(b_wr), .side_b_rd_i(b_rd),
    .side_b_data_bus_i(b_oe ? b_o : mb_d), .side_b_data_bus_o(b_o),
    .side_b_data_bus_oe_o(b_oe), .side_b_ready_o(b_rdy),
    .side_b_near_empty_flag_o(b_ne), .side_b_near_full_flag_o(b_nf),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack)
  );
  bfpf_side_model #(.P(16)) u_a (.clk_i(clk_i), .side_clk_o(a_clk), .wr_o(a_wr),
    .rd_o(a_rd), .ld_o(a_ld), .data_o(ma_d));
  bfpf_side_model #(.P(14)) u_b (.clk_i(clk_i), .side_clk_o(b_clk), .wr_o(b_wr),
    .rd_o(b_rd), .ld_o(), .data_o(mb_d));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Hang guard: the whole sequence needs well under a quarter of this
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic chk_val(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({35'h0, got}, {35'h0, exp});
  endtask
  task automatic final_report;
    if (num_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Classic single cycle; ack and read data taken at the same rising edge
  task automatic wb(input logic w, input logic [4:0] a, input logic [3:0] s,
                    input logic [31:0] d, output logic [31:0] r);
    {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, s, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    {cyc, stb} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic do_reset(input logic [1:0] s);
    rst_i <= 1'b1;
    {fs1, fs0} <= s;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (10) @(posedge clk_i);
  endtask
  // Fill one queue past full, then drain it past empty, far side idle meanwhile
  task automatic run(input bit fwd);
    logic [35:0] base;
    base = fwd ? 36'h5_0000_0000 : 36'h6_0000_0000;
    for (int n = 1; n <= 17; n++) begin
      if (fwd) u_a.ev(1'b1, 1'b0, 1'b0, base + 36'(n));
      else u_b.ev(1'b1, 1'b0, 1'b0, base + 36'(n));
      if (n inside {2, 3, 12, 13}) begin
        repeat (48) @(posedge clk_i);
        chk_bit(fwd ? b_ne : a_ne, n > 2);
        chk_bit(fwd ? a_nf : b_nf, n < 13);
        chk_bit(fwd ? a_oe : b_oe, 1'b0);
      end
    end
    chk_bit(fwd ? a_rdy : b_rdy, 1'b0);
    wb(1'b0, 5'h10, 4'hf, 32'h0, q);
    chk_val({31'h0, fwd ? q[4:0] : q[12:8]}, 36'h10);
    for (int n = 1; n <= 17; n++) begin
      if (fwd) u_b.ev(1'b0, 1'b1, 1'b0, 36'h0);
      else u_a.ev(1'b0, 1'b1, 1'b0, 36'h0);
      chk_bit(fwd ? b_oe : a_oe, 1'b1);
      repeat (4) @(posedge clk_i);
      chk_val(fwd ? b_o : a_o, base + 36'(n < 17 ? n : 16));
      if (n inside {13, 14}) begin
        repeat (48) @(posedge clk_i);
        chk_bit(fwd ? b_ne : a_ne, n < 14);
      end
    end
    chk_bit(fwd ? a_rdy : b_rdy, 1'b1);
  endtask
  initial begin
    {rst_i, sd, serial_program_select, fs0, fs1, cyc, stb, we} = 8'h80;
    {adr, sel, wdat} = 41'h0;
    // Strap codes 0, 1 and 2 after reset, with their near-full boundary at sixteen free
    for (int s = 0; s < 3; s++) begin
      do_reset(2'(s));
      for (int r = 0; r < 4; r++) begin
        wb(1'b0, 5'(r * 4), 4'hf, 32'h0, q);
        chk_val({4'h0, q}, 36'(ofs[s]));
      end
      repeat (48) @(posedge clk_i);
      chk_bit(a_nf, ofs[s] < 16);
      chk_bit(b_nf, ofs[s] < 16);
      chk_bit(a_ne, 1'b0);
      chk_bit(b_ne, 1'b0);
    end
    // Serial load, most significant bit first, then parallel load of 2, 3, 2, 3
    serial_program_select <= 1'b1;
    for (int i = 27; i >= 0; i--) begin
      sd <= ser[i];
      u_a.ev(1'b0, 1'b0, 1'b1, 36'h0);
    end
    for (int r = 0; r < 4; r++) begin
      wb(1'b0, 5'(r * 4), 4'hf, 32'h0, q);
      chk_val({4'h0, q}, {29'h0, ser[27 - 7 * r -: 7]});
    end
    serial_program_select <= 1'b0;
    for (int r = 0; r < 4; r++) u_a.ev(1'b0, 1'b0, 1'b1, 36'(2 + r % 2));
    // Masked write is dropped, full-width value kept, unmapped reads zero
    wb(1'b1, 5'h00, 4'he, 32'h7f, q);
    wb(1'b1, 5'h0c, 4'hf, 32'h7f, q);
    wb(1'b0, 5'h00, 4'hf, 32'h0, q);
    chk_val({4'h0, q}, 36'h2);
    wb(1'b0, 5'h0c, 4'hf, 32'h0, q);
    chk_val({4'h0, q}, 36'h7f);
    wb(1'b0, 5'h18, 4'hf, 32'h0, q);
    chk_val({4'h0, q}, 36'h0);
    wb(1'b1, 5'h0c, 4'hf, 32'h3, q);
    run(1'b1);
    run(1'b0);
    final_report();
  end
endmodule
